// ---- include/ussa_pkg.sv ----
package ussa_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_OPERAND_A = 8'h00;
    localparam logic [7:0] OFS_OPERAND_B = 8'h04;
    localparam logic [7:0] OFS_ACCUM     = 8'h08;
    localparam logic [7:0] OFS_CTRL      = 8'h0C;
    localparam logic [7:0] OFS_RESULT    = 8'h10;
    localparam logic [7:0] OFS_STATUS    = 8'h14;

    // Status register bit positions
    localparam int STAT_SAT_POS     = 0;
    localparam int STAT_UNPRED_POS  = 1;
    localparam int STAT_UNDEF_POS   = 2;

    // Reset values
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // Lane geometry
    localparam int HALF_W      = 16;
    localparam int BYTE_W      = 8;
    localparam int HALF_EXT_W  = 18;
    localparam int BYTE_EXT_W  = 10;
    localparam int SAD_W       = 10;
    localparam logic [4:0] HALF_SAT_POS = 5'h10;
    localparam logic [3:0] BYTE_SAT_POS = 4'h8;

    // Register numbers that give unpredictable results, and the accumulate field value that means none
    localparam logic [3:0] REG_NUM_STACK = 4'hD;
    localparam logic [3:0] REG_NUM_PC    = 4'hF;
    localparam logic [3:0] REG_NUM_NONE  = 4'hF;

    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [3:0] {
        OP_SAT_ADD_SUB_EXCHANGE = 4'h0,
        OP_SAT_SUB_ADD_EXCHANGE = 4'h1,
        OP_SAT_SUB_HALFWORDS    = 4'h2,
        OP_SAT_SUB_BYTES        = 4'h3,
        OP_BYTE_ABS_DIFF_SUM    = 4'h4,
        OP_BYTE_ABS_DIFF_SUM_ACC = 4'h5,
        OP_WORD_UNSIGNED_SAT    = 4'h6,
        OP_DUAL_HALF_UNSIGNED_SAT = 4'h7
    } ussa_op_type;

    // Gray coded along idle -> write -> read wait; idle -> read flips both bits
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ  = 2'b11
    } ussa_bus_type;

    // Control word; first field is the most significant
    typedef struct packed {
        logic [3:0]  src_m;
        logic [3:0]  src_n;
        logic [3:0]  dest;
        logic [3:0]  accumulate_register_field;
        logic [1:0]  shift_amount_low;
        logic [2:0]  shift_amount_high;
        logic        shift_type_bit;
        logic [4:0]  sat_imm;
        logic        cond_pass;
        ussa_op_type op;
    } ussa_ctrl_type;

    typedef struct packed {
        logic sticky_saturation_flag;
        logic unpredictable;
        logic undefined;
        logic done;
    } ussa_flags_type;

endpackage

// ---- verilog/ussa_clamp.sv ----
`timescale 1ns/1ns
module ussa_clamp #(
    parameter int IN_W  = 18,
    parameter int OUT_W = 16,
    parameter int POS_W = 5
) (
    // Signed intermediate and clamp position
    input  wire logic signed [IN_W-1:0]  val,
    input  wire logic [POS_W-1:0]        pos,
    // Clamped value and saturation indication
    output logic [OUT_W-1:0]             res,
    output logic                         sat
);
    localparam logic [IN_W-1:0] ONE = {{(IN_W-1){1'b0}}, 1'b1};

    logic [IN_W-1:0] limit;

    always_comb begin
        limit = (ONE << pos) - ONE;
        if (val[IN_W-1]) begin
            res = '0;
            sat = 1'b1;
        end else if ($unsigned(val) > limit) begin
            res = limit[OUT_W-1:0];
            sat = 1'b1;
        end else begin
            res = val[OUT_W-1:0];
            sat = 1'b0;
        end
    end
endmodule

// ---- verilog/ussa_alu.sv ----
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
module ussa_alu
    import ussa_pkg::*;
#(
    parameter bit HAVE_DSP = 1'b1
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Datapath results toward write-back
    output logic [31:0]      result,
    output ussa_pkg::ussa_flags_type flags
);
    import ussa_pkg::*;

    typedef struct packed {
        ussa_bus_type   phase;
        logic [7:0]     addr;
        logic           wr_word;
        logic [31:0]    hrdata;
        logic           hreadyout;
        logic           hresp;
        logic [31:0]    opa;
        logic [31:0]    opb;
        logic [31:0]    acc;
        ussa_ctrl_type  ctrl;
        logic           go;
        logic [31:0]    result;
        ussa_flags_type flags;
    } ussa_state_type;

    // Reset image in one place; bus comes up ready, datapath idle
    localparam ussa_state_type STATE_RESET = '{
        phase:     BUS_IDLE,
        addr:      8'h00,
        wr_word:   1'b0,
        hrdata:    WORD_RESET,
        hreadyout: 1'b1,
        hresp:     1'b0,
        opa:       WORD_RESET,
        opb:       WORD_RESET,
        acc:       WORD_RESET,
        ctrl:      WORD_RESET,
        go:        1'b0,
        result:    WORD_RESET,
        flags:     4'h0
    };

    ussa_state_type q;
    ussa_state_type d;

    // Lane operands and clamp outputs
    logic signed [HALF_EXT_W-1:0] half_in  [2];
    logic [HALF_W-1:0]            half_res [2];
    logic                         half_sat [2];
    logic [4:0]                   half_pos;
    logic signed [BYTE_EXT_W-1:0] byte_in  [4];
    logic [BYTE_W-1:0]            byte_res [4];
    logic                         byte_sat [4];
    logic [31:0]                  shifted;
    logic [31:0]                  word_res;
    logic                         word_sat;
    logic [4:0]                   shift_amt;
    logic [SAD_W-1:0]             sad_sum;
    logic [BYTE_EXT_W-1:0]        abs_diff [4];

    // Decode results
    ussa_op_type                  eff_op;
    logic                         is_undef;
    logic                         is_unpred;
    logic                         uses_m;
    logic [31:0]                  op_result;
    logic                         op_sat;

    always_comb begin
        shift_amt = {q.ctrl.shift_amount_high, q.ctrl.shift_amount_low};
        // No carry input exists: the shifted operand cannot see it
        if (q.ctrl.shift_type_bit) begin
            shifted = $unsigned($signed(q.opa) >>> shift_amt);
        end else begin
            shifted = q.opa << shift_amt;
        end
    end

    always_comb begin
        eff_op = q.ctrl.op;
        is_undef = 1'b0;
        if (q.ctrl.op == OP_BYTE_ABS_DIFF_SUM_ACC &&
            q.ctrl.accumulate_register_field == REG_NUM_NONE) begin
            eff_op = OP_BYTE_ABS_DIFF_SUM;
        end
        if (q.ctrl.op == OP_WORD_UNSIGNED_SAT && q.ctrl.shift_type_bit && shift_amt == 5'h00) begin
            if (HAVE_DSP) begin
                eff_op = OP_DUAL_HALF_UNSIGNED_SAT;
            end else begin
                is_undef = 1'b1;
            end
        end
        if (q.ctrl.op > OP_DUAL_HALF_UNSIGNED_SAT) begin
            is_undef = 1'b1;
        end
    end

    always_comb begin
        uses_m = (eff_op != OP_WORD_UNSIGNED_SAT) && (eff_op != OP_DUAL_HALF_UNSIGNED_SAT);
        is_unpred = (q.ctrl.dest == REG_NUM_STACK) || (q.ctrl.dest == REG_NUM_PC) ||
                    (q.ctrl.src_n == REG_NUM_STACK) || (q.ctrl.src_n == REG_NUM_PC) ||
                    (uses_m && (q.ctrl.src_m == REG_NUM_STACK || q.ctrl.src_m == REG_NUM_PC));
        if (eff_op == OP_BYTE_ABS_DIFF_SUM_ACC && q.ctrl.accumulate_register_field == REG_NUM_STACK) begin
            is_unpred = 1'b1;
        end
    end

    // Halfword lane operands, 18-bit signed so nothing wraps
    always_comb begin
        half_pos = HALF_SAT_POS;
        case (eff_op)
            OP_SAT_ADD_SUB_EXCHANGE: begin
                half_in[0] = $signed({2'b00, q.opa[15:0]}) - $signed({2'b00, q.opb[31:16]});
                half_in[1] = $signed({2'b00, q.opa[31:16]}) + $signed({2'b00, q.opb[15:0]});
            end
            OP_SAT_SUB_ADD_EXCHANGE: begin
                half_in[0] = $signed({2'b00, q.opa[15:0]}) + $signed({2'b00, q.opb[31:16]});
                half_in[1] = $signed({2'b00, q.opa[31:16]}) - $signed({2'b00, q.opb[15:0]});
            end
            OP_DUAL_HALF_UNSIGNED_SAT: begin
                half_in[0] = {{2{q.opa[15]}}, q.opa[15:0]};
                half_in[1] = {{2{q.opa[31]}}, q.opa[31:16]};
                half_pos = {1'b0, q.ctrl.sat_imm[3:0]};
            end
            default: begin
                half_in[0] = $signed({2'b00, q.opa[15:0]}) - $signed({2'b00, q.opb[15:0]});
                half_in[1] = $signed({2'b00, q.opa[31:16]}) - $signed({2'b00, q.opb[31:16]});
            end
        endcase
    end

    // Byte lanes serve both the saturating subtract and the absolute difference sum
    always_comb begin
        sad_sum = '0;
        for (int i = 0; i < 4; i++) begin
            byte_in[i] = $signed({2'b00, q.opa[i*BYTE_W +: BYTE_W]}) -
                         $signed({2'b00, q.opb[i*BYTE_W +: BYTE_W]});
            abs_diff[i] = byte_in[i][BYTE_EXT_W-1] ? $unsigned(-byte_in[i]) : $unsigned(byte_in[i]);
            sad_sum = sad_sum + abs_diff[i];
        end
    end

    for (genvar g = 0; g < 2; g++) begin : g_half
        ussa_clamp #(
            .IN_W  (HALF_EXT_W),
            .OUT_W (HALF_W),
            .POS_W (5)
        ) u_half (
            .val (half_in[g]),
            .pos (half_pos),
            .res (half_res[g]),
            .sat (half_sat[g])
        );
    end

    for (genvar g = 0; g < 4; g++) begin : g_byte
        ussa_clamp #(
            .IN_W  (BYTE_EXT_W),
            .OUT_W (BYTE_W),
            .POS_W (4)
        ) u_byte (
            .val (byte_in[g]),
            .pos (BYTE_SAT_POS),
            .res (byte_res[g]),
            .sat (byte_sat[g])
        );
    end

    ussa_clamp #(
        .IN_W  (32),
        .OUT_W (32),
        .POS_W (5)
    ) u_word (
        .val ($signed(shifted)),
        .pos (q.ctrl.sat_imm),
        .res (word_res),
        .sat (word_sat)
    );

    // Result and saturation per operation
    always_comb begin
        op_sat = 1'b0;
        case (eff_op)
            OP_SAT_ADD_SUB_EXCHANGE,
            OP_SAT_SUB_ADD_EXCHANGE,
            OP_SAT_SUB_HALFWORDS: begin
                op_result = {half_res[1], half_res[0]};
            end
            OP_SAT_SUB_BYTES: begin
                op_result = {byte_res[3], byte_res[2], byte_res[1], byte_res[0]};
            end
            OP_BYTE_ABS_DIFF_SUM: begin
                op_result = {{(32-SAD_W){1'b0}}, sad_sum};
            end
            OP_BYTE_ABS_DIFF_SUM_ACC: begin
                op_result = q.acc + {{(32-SAD_W){1'b0}}, sad_sum};
            end
            OP_WORD_UNSIGNED_SAT: begin
                op_result = word_res;
                op_sat = word_sat;
            end
            OP_DUAL_HALF_UNSIGNED_SAT: begin
                op_result = {half_res[1], half_res[0]};
                op_sat = half_sat[0] | half_sat[1];
            end
            default: begin
                op_result = q.result;
            end
        endcase
    end

    function automatic logic [31:0] read_mux(input ussa_state_type s);
        logic [31:0] v;
        v = WORD_RESET;
        case (s.addr)
            OFS_OPERAND_A: v = s.opa;
            OFS_OPERAND_B: v = s.opb;
            OFS_ACCUM:     v = s.acc;
            OFS_CTRL:      v = s.ctrl;
            OFS_RESULT:    v = s.result;
            OFS_STATUS: begin
                v[STAT_SAT_POS]    = s.flags.sticky_saturation_flag;
                v[STAT_UNPRED_POS] = s.flags.unpredictable;
                v[STAT_UNDEF_POS]  = s.flags.undefined;
            end
            default:       v = WORD_RESET;
        endcase
        return v;
    endfunction

    always_comb begin
        d = q;
        d.go = 1'b0;
        d.flags.done = 1'b0;
        // Data phase of the previous transfer
        case (q.phase)
            BUS_WRITE: begin
                if (q.wr_word) begin
                    case (q.addr)
                        OFS_OPERAND_A: d.opa = hwdata;
                        OFS_OPERAND_B: d.opb = hwdata;
                        OFS_ACCUM:     d.acc = hwdata;
                        OFS_CTRL: begin
                            d.ctrl = hwdata;
                            d.go = 1'b1;
                        end
                        OFS_STATUS: begin
                            if (hwdata[STAT_SAT_POS]) begin
                                d.flags.sticky_saturation_flag = 1'b0;
                            end
                        end
                        default: d.opa = q.opa;
                    endcase
                end
            end
            BUS_READ: begin
                // Wait state lets a write just before the read land first
                d.hrdata = read_mux(q);
                d.hreadyout = 1'b1;
            end
            default: d.hrdata = q.hrdata;
        endcase
        // Address phase
        d.phase = BUS_IDLE;
        if (hsel && htrans[1] && hready) begin
            d.addr = haddr[7:0];
            d.wr_word = (hsize == HSIZE_WORD);
            if (hwrite) begin
                d.phase = BUS_WRITE;
            end else begin
                d.phase = BUS_READ;
                d.hreadyout = 1'b0;
            end
        end
        // Execute after the write; a set here beats a clear above
        if (q.go) begin
            d.flags.done = 1'b1;
            // Undefined reported even when the condition fails
            d.flags.undefined = is_undef;
            if (q.ctrl.cond_pass && !is_undef) begin
                // Unpredictable cases still write; software sees the flag
                d.result = op_result;
                d.flags.unpredictable = is_unpred;
                if (op_sat) begin
                    d.flags.sticky_saturation_flag = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    assign hrdata    = q.hrdata;
    assign hreadyout = q.hreadyout;
    assign hresp     = q.hresp;
    assign result    = q.result;
    assign flags     = q.flags;

endmodule

// ---- dv/ussa_alu_asserts.sv ----
`timescale 1ns/1ns
module ussa_alu_asserts
    import ussa_pkg::*;
(
    // Clock and reset
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    // Bus request
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic                    hready,
    // Bus answer and datapath outputs
    input  wire logic                    hreadyout,
    input  wire logic                    hresp,
    input  wire logic [31:0]             result,
    input  wire ussa_pkg::ussa_flags_type flags
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
    chk_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
        else $error("write inserted a wait");
    chk_ctrl_done: assert property (hsel && htrans[1] && hready && hwrite && hsize == HSIZE_WORD
        && haddr[7:0] == OFS_CTRL |-> ##3 flags.done) else $error("no done after control write");
    chk_done_cause: assert property (flags.done |-> $past(hsel && htrans[1] && hready && hwrite
        && hsize == HSIZE_WORD && haddr[7:0] == OFS_CTRL, 3)) else $error("done without control write");
    chk_result_cause: assert property ($changed(result) |-> flags.done)
        else $error("result moved without an operation");
    chk_sticky_cause: assert property ($rose(flags.sticky_saturation_flag) |-> flags.done)
        else $error("sticky flag set without an operation");
    chk_unpred_cause: assert property ($changed(flags.unpredictable) |-> flags.done)
        else $error("unpredictable moved without an operation");
endmodule

bind ussa_alu ussa_alu_asserts u_ussa_alu_asserts (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .result(result), .flags(flags));

// ---- dv/ussa_host.sv ----
`timescale 1ns/1ns
module ussa_host (
    // Clock and bus answer
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Bus request
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // Single word transfer; released write data flips so stale values never match
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        hwdata <= ~d;
    endtask
endmodule

// ---- dv/unsigned_saturating_simd_alu_test.sv ----
`timescale 1ns/1ns
module unsigned_saturating_simd_alu_test;
    import ussa_pkg::*;
    logic           hclk;
    logic           hresetn;
    logic           hsel;
    logic [31:0]    haddr;
    logic [1:0]     htrans;
    logic           hwrite;
    logic [2:0]     hsize;
    logic [31:0]    hwdata;
    logic [31:0]    hrdata;
    logic           hreadyout;
    logic           hresp;
    logic [31:0]    result;
    ussa_flags_type flags;
    integer         seed = 32'hcc46;
    int             bad_count = 0;
    int             samples_checked = 0;
    logic [31:0]    last_res = 32'h0;
    logic           last_unp = 1'b0;
    logic [31:0]    a;
    logic [31:0]    b;
    logic [31:0]    acc;

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    ussa_host u_ussa_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    ussa_alu u_ussa_alu (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .result(result), .flags(flags));

    function automatic longint u(logic [31:0] x);
        return longint'(x);
    endfunction

    function automatic longint clampu(longint v, int n);
        longint m;
        m = (longint'(1) << n) - 1;
        return (v < 0) ? 0 : ((v > m) ? m : v);
    endfunction

    // Result in bits 31:0, saturation in bit 32
    function automatic logic [32:0] expect_op(ussa_ctrl_type c);
        logic [31:0] r;
        logic        s;
        longint      v;
        longint      t;
        int          n;
        r = 32'h0;
        s = 1'b0;
        t = 0;
        n = {c.shift_amount_high, c.shift_amount_low};
        if (c.op == OP_DUAL_HALF_UNSIGNED_SAT || (c.op == OP_WORD_UNSIGNED_SAT && c.shift_type_bit && n == 0)) begin
            for (int h = 0; h < 2; h++) begin
                v = longint'($signed(a[16*h+:16]));
                t = clampu(v, c.sat_imm[3:0]);
                s |= (t != v);
                r[16*h+:16] = 16'(t);
            end
        end else if (c.op == OP_WORD_UNSIGNED_SAT) begin
            r = c.shift_type_bit ? 32'($signed(a) >>> n) : a << n;
            v = longint'($signed(r));
            t = clampu(v, c.sat_imm);
            s = (t != v);
            r = 32'(t);
        end else if (c.op == OP_SAT_ADD_SUB_EXCHANGE) begin
            r = {16'(clampu(u(a[31:16]) + u(b[15:0]), 16)), 16'(clampu(u(a[15:0]) - u(b[31:16]), 16))};
        end else if (c.op == OP_SAT_SUB_ADD_EXCHANGE) begin
            r = {16'(clampu(u(a[31:16]) - u(b[15:0]), 16)), 16'(clampu(u(a[15:0]) + u(b[31:16]), 16))};
        end else if (c.op == OP_SAT_SUB_HALFWORDS) begin
            for (int h = 0; h < 2; h++) r[16*h+:16] = 16'(clampu(u(a[16*h+:16]) - u(b[16*h+:16]), 16));
        end else if (c.op == OP_SAT_SUB_BYTES) begin
            for (int k = 0; k < 4; k++) r[8*k+:8] = 8'(clampu(u(a[8*k+:8]) - u(b[8*k+:8]), 8));
        end else begin
            for (int k = 0; k < 4; k++) begin
                v = u(a[8*k+:8]) - u(b[8*k+:8]);
                t += (v < 0) ? -v : v;
            end
            if (c.op == OP_BYTE_ABS_DIFF_SUM_ACC && c.accumulate_register_field != 4'hF) t += u(acc);
            r = 32'(t);
        end
        return {s, r};
    endfunction

    function automatic logic unp(ussa_ctrl_type c);
        return (c.dest inside {REG_NUM_STACK, REG_NUM_PC}) || (c.src_n inside {REG_NUM_STACK, REG_NUM_PC})
            || (c.op <= OP_BYTE_ABS_DIFF_SUM_ACC && (c.src_m inside {REG_NUM_STACK, REG_NUM_PC}))
            || (c.op == OP_BYTE_ABS_DIFF_SUM_ACC && c.accumulate_register_field == REG_NUM_STACK);
    endfunction

    task automatic check(string name, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic run(ussa_ctrl_type c);
        logic [32:0] e;
        logic [31:0] q;
        logic        ok;
        e = expect_op(c);
        ok = (c.op <= OP_DUAL_HALF_UNSIGNED_SAT);
        if (!c.cond_pass || !ok) e = {1'b0, last_res};
        else last_unp = unp(c);
        u_ussa_host.xfer(1'b1, OFS_STATUS, 32'h1, q);
        u_ussa_host.xfer(1'b1, OFS_OPERAND_A, a, q);
        u_ussa_host.xfer(1'b1, OFS_OPERAND_B, b, q);
        u_ussa_host.xfer(1'b1, OFS_ACCUM, acc, q);
        u_ussa_host.xfer(1'b1, OFS_CTRL, c, q);
        u_ussa_host.xfer(1'b0, OFS_RESULT, 32'h0, q);
        check("result", e[31:0], q);
        check("result port", e[31:0], result);
        u_ussa_host.xfer(1'b0, OFS_STATUS, 32'h0, q);
        check("status", {29'h0, !ok, last_unp, e[32]}, q);
        check("flags hresp", {27'h0, 1'b0, e[32], last_unp, !ok, 1'b0}, {27'h0, hresp, flags});
        last_res = e[31:0];
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #800000;
        bad_count++;
        stop_test();
    end

    initial begin
        ussa_ctrl_type c;
        logic [31:0]   q;
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("reset result", WORD_RESET, result);
        for (int i = 0; i < 64; i++) begin
            c = ussa_ctrl_type'($random(seed));
            c.op = ussa_op_type'({1'b0, c.op[2:0]});
            if (i < 24) c.op = ussa_op_type'(4'(i % 8));
            c.cond_pass = (i % 9 != 8);
            a = $random(seed);
            b = $random(seed);
            acc = $random(seed);
            // One lane extreme pushes the subtracting clamps to zero; the other puts each subtract on the top value, unclamped
            if (i % 5 == 1) begin
                a = 32'h8000_0000;
                b = 32'hFFFF_FFFF;
            end
            if (i % 5 == 2) begin
                a = 32'hFFFF_FFFF;
                b = 32'h0000_0000;
            end
            if (i == 30 || i == 31) begin
                c.op = OP_WORD_UNSIGNED_SAT;
                c.shift_type_bit = 1'b1;
                {c.shift_amount_high, c.shift_amount_low} = 5'h00;
            end
            if (i == 32) begin
                c.op = OP_BYTE_ABS_DIFF_SUM_ACC;
                c.accumulate_register_field = 4'hF;
            end
            run(c);
        end
        c.op = ussa_op_type'(4'h8);
        run(c);
        u_ussa_host.xfer(1'b0, 8'h40, 32'h0, q);
        check("unmapped read", 32'h0, q);
        stop_test();
    end
endmodule
